// ==== smc_pkg.sv ====
// package for the switch mac control register bank
package smc_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CHIP_IDENTITY = 8'h00;
  localparam logic [7:0] ADDR_MAC_MISC_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_BANDWIDTH_MODE = 8'h02;
  localparam logic [7:0] ADDR_PORT_ONE_RATE_LIMIT = 8'h03;
  localparam logic [7:0] ADDR_PORT_TWO_RATE_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_PORT_THREE_RATE_LIMIT = 8'h05;
  localparam logic [7:0] ADDR_RECEIVE_ENABLE = 8'h06;
  localparam logic [7:0] ADDR_RESERVED_SEVEN = 8'h07;
  localparam logic [7:0] ADDR_PRIORITY_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_LOOPBACK_FRAME_FORMAT = 8'h09;
  localparam logic [7:0] ADDR_DATA_PATH_SELECT = 8'h0a;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_MAC_MISC_CONFIG = 16'h3892;
  localparam logic [15:0] RST_BANDWIDTH_MODE = 16'h0707;
  localparam logic [15:0] RST_RATE_LIMIT = 16'hffff;
  localparam logic [15:0] RST_RECEIVE_ENABLE = 16'h0007;
  localparam logic [15:0] RST_RESERVED_SEVEN = 16'hffff;
  localparam logic [15:0] RST_PRIORITY_CONFIG = 16'h0000;
  localparam logic [15:0] RST_LOOPBACK_FRAME_FORMAT = 16'h0000;
  localparam logic [15:0] RST_DATA_PATH_SELECT = 16'h00cf;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;

  // ------------------------------------------------------------
  // mac_misc_config fields
  // ------------------------------------------------------------
  localparam int MISC_BLINK_HI = 14;
  localparam int MISC_BLINK_LO = 13;
  localparam int MISC_LED_MODE_HI = 12;
  localparam int MISC_LED_MODE_LO = 11;
  localparam int MISC_STP_CPU = 10;
  localparam int MISC_AUTH_CPU = 9;
  localparam int MISC_SLOW_FWD = 8;
  localparam int MISC_PAUSE_FLOOD = 5;
  localparam int MISC_BPDU_FLOOD = 4;
  localparam int MISC_IPG_COMP = 3;
  localparam int MISC_BP_CARRIER = 2;
  localparam int MISC_BACKOFF_EN = 1;
  localparam int MISC_DROP16_EN = 0;

  // ------------------------------------------------------------
  // other field positions
  // ------------------------------------------------------------
  localparam int BWM_INGRESS_LO = 8;
  localparam int BWM_EGRESS_LO = 0;
  localparam int RATE_INGRESS_HI = 15;
  localparam int RATE_INGRESS_LO = 8;
  localparam int RATE_EGRESS_HI = 7;
  localparam int RATE_EGRESS_LO = 0;
  localparam int PRI_TAG_EN = 4;
  localparam int LB_BCAST = 7;
  localparam int LB_FMT_HI = 6;
  localparam int LB_FMT_LO = 4;
  localparam int DP_DUAL_PHY = 8;
  localparam int DP_DTE_LO = 6;
  localparam int DP_EXT_LO = 4;
  localparam int DP_SEL_LO = 0;
  localparam int NUM_PORTS = 3;
  localparam int NUM_EXT_PORTS = 2;
  localparam logic [1:0] CPU_PORT = 2'd2;

  // ------------------------------------------------------------
  // rates, timing, frame constants
  // ------------------------------------------------------------
  localparam logic [16:0] STEP_FINE_KBPS = 17'd32;
  localparam logic [16:0] STEP_COARSE_KBPS = 17'd512;
  localparam int IPG_EXTRA_PPM = 80;
  localparam int MAX_COLLISIONS = 16;
  localparam int CLOCK_HZ = 40000000;
  localparam int BLINK_STEP_MS = 50;
  localparam int BLINK_STEP_CYCLES = CLOCK_HZ / 1000 * BLINK_STEP_MS;
  localparam logic [47:0] GROUP_BASE = 48'h0180c2000000;
  localparam logic [3:0] GRP_STP = 4'h0;
  localparam logic [3:0] GRP_PAUSE = 4'h1;
  localparam logic [3:0] GRP_SLOW = 4'h2;
  localparam logic [3:0] GRP_AUTH = 4'h3;
  localparam logic [47:0] DA_BROADCAST = 48'hffffffffffff;
  localparam logic [2:0] LB_FMT_DEFAULT = 3'b000;
  localparam logic [15:0] LB_WORD_DEFAULT = 16'h55aa;
  localparam logic [2:0] PORTS_NONE = 3'b000;
  localparam logic [2:0] PORTS_ALL = 3'b111;
  localparam logic [2:0] PORTS_CPU = 3'b100;
  localparam logic [2:0] PORTS_PAIR = 3'b011;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    SMC_PATH_INTERNAL = 5'b00001,
    SMC_PATH_RS232 = 5'b00010,
    SMC_PATH_SMII = 5'b00100,
    SMC_PATH_REV_MII = 5'b01000,
    SMC_PATH_MII = 5'b10000
  } smc_path_t;

  typedef struct packed {
    logic [1:0] led_mode;
    logic ipg_comp;
    logic bp_carrier;
    logic backoff_en;
    logic drop16_en;
    logic [2:0] rx_en;
    logic dual_phy;
    logic [1:0] dte;
    logic [47:0] lb_da;
    logic [15:0] lb_word;
  } smc_cfg_t;

  typedef struct packed {
    logic valid;
    logic [47:0] da;
    logic [1:0] port;
    logic tag_high;
  } smc_frame_t;

  typedef struct packed {
    logic valid;
    logic [2:0] fwd;
    logic absorb;
    logic high_pri;
  } smc_verdict_t;

  typedef struct packed {
    logic [16:0] ingress_kbps;
    logic [16:0] egress_kbps;
  } smc_rate_t;

endpackage : smc_pkg

// ==== smc_blink.sv ====
// led blink generator with selectable half period
`timescale 1ns/10ps
module smc_blink #(
  parameter int STEP_CYCLES = smc_pkg::BLINK_STEP_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // control
  input wire logic [1:0] speed_i,
  // output
  output logic blink_o
);
  import smc_pkg::*;

  logic [31:0] count;
  logic [31:0] half_period;
  logic [1:0] speed_q;

  assign half_period = STEP_CYCLES * (32'(speed_i) + 32'd1);

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      count <= 32'h0;
      blink_o <= 1'b0;
      speed_q <= speed_i;
    end else if (ce_i) begin
      speed_q <= speed_i;
      // restart on speed change, no short half period
      if (speed_i != speed_q) begin
        count <= 32'h0;
      end else if (count >= half_period - 32'd1) begin
        count <= 32'h0;
        blink_o <= ~blink_o;
      end else begin
        count <= count + 32'd1;
      end
    end
  end

endmodule : smc_blink

// ==== smc_regs.sv ====
// mac control register bank with frame verdict logic
`timescale 1ns/10ps
// Contract
// - blink half period 50 to 200 ms
// - two-bit led display mode, default 11
// - stp group frames flood or to cpu
// - auth frames to cpu or follow bpdu
// - slow protocol discarded, else cpu or flood
// - pause absorbed unless flood bit set
// - bpdu range discarded or flooded, default flood
// - optional 80 ppm transmit gap extension
// - back-pressure by collision or carrier sense
// - back-off enable and 16-collision drop
// - per direction step 32 or 512 kbps
// - limit equals step times eight-bit n
// - per port receive enable, default on
// - high priority from port or tag
// - loop-back da unicast or broadcast
// - loop-back payload pattern, default 55aa
// - dual phy stops port one-two forwarding
// - serial port dce or dte select
// - internal phy or external interface
// - external interface code decode, default mii
// - third port is cpu only when flagged
module smc_regs #(
  parameter int BLINK_STEP_CYCLES = smc_pkg::BLINK_STEP_CYCLES,
  // arbitrary neutral identity value
  parameter logic [15:0] CHIP_ID = 16'h0a5c,
  // arbitrary neutral unicast destination
  parameter logic [47:0] LB_UNICAST_DA = 48'h020000000001,
  // payload for undefined format codes
  parameter logic [15:0] LB_WORD_OTHER = 16'h0000
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // external configuration
  input wire logic cpu_port_flag_i,
  // frame classification
  input wire smc_pkg::smc_frame_t frame_i,
  output smc_pkg::smc_verdict_t verdict_o,
  // configuration outputs
  output smc_pkg::smc_cfg_t cfg_o,
  output smc_pkg::smc_rate_t [2:0] rate_o,
  output smc_pkg::smc_path_t [1:0] path_o,
  output logic led_blink_o
);
  import smc_pkg::*;

  // ------------------------------------------------------------
  // decode functions
  // ------------------------------------------------------------
  function automatic smc_path_t decode_path(input logic ext, input logic [1:0] sel);
    smc_path_t p;
    p = SMC_PATH_INTERNAL;
    if (ext) begin
      unique case (sel)
        2'b00: p = SMC_PATH_RS232;
        2'b01: p = SMC_PATH_SMII;
        2'b10: p = SMC_PATH_REV_MII;
        2'b11: p = SMC_PATH_MII;
      endcase
    end
    return p;
  endfunction : decode_path

  function automatic logic [16:0] rate_kbps(input logic coarse, input logic [7:0] n);
    logic [16:0] step;
    step = coarse ? STEP_COARSE_KBPS : STEP_FINE_KBPS;
    return 17'(step * {9'h0, n});
  endfunction : rate_kbps

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [15:0] mac_misc_config;
  logic [15:0] bandwidth_mode;
  logic [15:0] rate_limit [NUM_PORTS];
  logic [15:0] receive_enable;
  logic [15:0] priority_config;
  logic [15:0] loopback_frame_format;
  logic [15:0] data_path_select;
  logic wr;

  assign wr = ce_i && reg_wr_i;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      mac_misc_config <= RST_MAC_MISC_CONFIG;
      bandwidth_mode <= RST_BANDWIDTH_MODE;
      receive_enable <= RST_RECEIVE_ENABLE;
      priority_config <= RST_PRIORITY_CONFIG;
      loopback_frame_format <= RST_LOOPBACK_FRAME_FORMAT;
      data_path_select <= RST_DATA_PATH_SELECT;
    end else if (wr) begin
      unique case (reg_addr_i)
        ADDR_MAC_MISC_CONFIG: mac_misc_config <= reg_wdata_i;
        ADDR_BANDWIDTH_MODE: bandwidth_mode <= reg_wdata_i;
        ADDR_RECEIVE_ENABLE: receive_enable <= reg_wdata_i;
        ADDR_PRIORITY_CONFIG: priority_config <= reg_wdata_i;
        ADDR_LOOPBACK_FRAME_FORMAT: loopback_frame_format <= reg_wdata_i;
        ADDR_DATA_PATH_SELECT: data_path_select <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_rate
    always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
        rate_limit[p] <= RST_RATE_LIMIT;
      end else if (wr && reg_addr_i == ADDR_PORT_ONE_RATE_LIMIT + 8'(p)) begin
        rate_limit[p] <= reg_wdata_i;
      end
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = READ_UNMAPPED;
    unique case (reg_addr_i)
      ADDR_CHIP_IDENTITY: next_rdata = CHIP_ID;
      ADDR_MAC_MISC_CONFIG: next_rdata = mac_misc_config;
      ADDR_BANDWIDTH_MODE: next_rdata = bandwidth_mode;
      ADDR_PORT_ONE_RATE_LIMIT: next_rdata = rate_limit[0];
      ADDR_PORT_TWO_RATE_LIMIT: next_rdata = rate_limit[1];
      ADDR_PORT_THREE_RATE_LIMIT: next_rdata = rate_limit[2];
      ADDR_RECEIVE_ENABLE: next_rdata = receive_enable;
      ADDR_RESERVED_SEVEN: next_rdata = RST_RESERVED_SEVEN;
      ADDR_PRIORITY_CONFIG: next_rdata = priority_config;
      ADDR_LOOPBACK_FRAME_FORMAT: next_rdata = loopback_frame_format;
      ADDR_DATA_PATH_SELECT: next_rdata = data_path_select;
      default: next_rdata = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= READ_UNMAPPED;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration outputs
  // ------------------------------------------------------------
  smc_cfg_t next_cfg;

  always_comb begin
    next_cfg.led_mode = mac_misc_config[MISC_LED_MODE_HI:MISC_LED_MODE_LO];
    next_cfg.ipg_comp = mac_misc_config[MISC_IPG_COMP];
    next_cfg.bp_carrier = mac_misc_config[MISC_BP_CARRIER];
    next_cfg.backoff_en = mac_misc_config[MISC_BACKOFF_EN];
    next_cfg.drop16_en = mac_misc_config[MISC_DROP16_EN];
    next_cfg.rx_en = receive_enable[NUM_PORTS-1:0];
    next_cfg.dual_phy = data_path_select[DP_DUAL_PHY];
    next_cfg.dte = data_path_select[DP_DTE_LO +: NUM_EXT_PORTS];
    next_cfg.lb_da = loopback_frame_format[LB_BCAST] ? DA_BROADCAST : LB_UNICAST_DA;
    next_cfg.lb_word = (loopback_frame_format[LB_FMT_HI:LB_FMT_LO] == LB_FMT_DEFAULT) ?
                       LB_WORD_DEFAULT : LB_WORD_OTHER;
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cfg_o <= '0;
    end else if (ce_i) begin
      cfg_o <= next_cfg;
    end
  end

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_kbps
    always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
        rate_o[p] <= '0;
      end else if (ce_i) begin
        rate_o[p].ingress_kbps <= rate_kbps(bandwidth_mode[BWM_INGRESS_LO + p],
                                            rate_limit[p][RATE_INGRESS_HI:RATE_INGRESS_LO]);
        rate_o[p].egress_kbps <= rate_kbps(bandwidth_mode[BWM_EGRESS_LO + p],
                                           rate_limit[p][RATE_EGRESS_HI:RATE_EGRESS_LO]);
      end
    end
  end

  for (genvar p = 0; p < NUM_EXT_PORTS; p++) begin : g_path
    always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
        path_o[p] <= SMC_PATH_INTERNAL;
      end else if (ce_i) begin
        path_o[p] <= decode_path(data_path_select[DP_EXT_LO + p],
                                 data_path_select[DP_SEL_LO + 2*p +: 2]);
      end
    end
  end

  // ------------------------------------------------------------
  // frame verdict
  // ------------------------------------------------------------
  smc_verdict_t next_verdict;
  logic cpu_mode;
  logic group_hit;
  logic [3:0] group_low;
  logic [2:0] flood;

  always_comb begin
    cpu_mode = cpu_port_flag_i;
    group_hit = (frame_i.da[47:4] == GROUP_BASE[47:4]);
    group_low = frame_i.da[3:0];
    flood = PORTS_ALL & ~(3'b001 << frame_i.port);
    // no forwarding between first two ports
    if (next_cfg.dual_phy && frame_i.port != CPU_PORT) begin
      flood = flood & ~PORTS_PAIR;
    end
    next_verdict.valid = frame_i.valid;
    next_verdict.absorb = 1'b0;
    next_verdict.fwd = flood;
    if (group_hit) begin
      unique case (group_low)
        GRP_STP: next_verdict.fwd = (mac_misc_config[MISC_STP_CPU] && cpu_mode) ?
                                    PORTS_CPU : flood;
        GRP_PAUSE: begin
          next_verdict.absorb = !mac_misc_config[MISC_PAUSE_FLOOD];
          next_verdict.fwd = mac_misc_config[MISC_PAUSE_FLOOD] ? flood : PORTS_NONE;
        end
        GRP_SLOW: begin
          if (!mac_misc_config[MISC_SLOW_FWD]) begin
            next_verdict.fwd = PORTS_NONE;
          end else begin
            next_verdict.fwd = cpu_mode ? PORTS_CPU : flood;
          end
        end
        GRP_AUTH: begin
          if (mac_misc_config[MISC_AUTH_CPU] && cpu_mode &&
              !mac_misc_config[MISC_BPDU_FLOOD]) begin
            next_verdict.fwd = PORTS_CPU;
          end else begin
            next_verdict.fwd = mac_misc_config[MISC_BPDU_FLOOD] ? flood : PORTS_NONE;
          end
        end
        default: next_verdict.fwd = mac_misc_config[MISC_BPDU_FLOOD] ? flood : PORTS_NONE;
      endcase
    end
    if (frame_i.port > CPU_PORT || !receive_enable[frame_i.port]) begin
      next_verdict.fwd = PORTS_NONE;
      next_verdict.absorb = 1'b0;
    end
    next_verdict.high_pri = (frame_i.port <= CPU_PORT && priority_config[frame_i.port]) ||
                            (priority_config[PRI_TAG_EN] && frame_i.tag_high);
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      verdict_o <= '0;
    end else if (ce_i) begin
      verdict_o <= next_verdict;
    end
  end

  // ------------------------------------------------------------
  // led blink
  // ------------------------------------------------------------
  smc_blink #(
    .STEP_CYCLES(BLINK_STEP_CYCLES)
  ) u_blink (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .speed_i(mac_misc_config[MISC_BLINK_HI:MISC_BLINK_LO]),
    .blink_o(led_blink_o)
  );

endmodule : smc_regs

// ==== smc_regs_checker.sv ====
// assertion checker for the switch mac control register bank
`timescale 1ns/10ps
module smc_regs_checker #(
  parameter int BLINK_STEP_CYCLES = smc_pkg::BLINK_STEP_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_rvalid_o,
  // frames and configuration
  input wire smc_pkg::smc_frame_t frame_i,
  input wire smc_pkg::smc_verdict_t verdict_o,
  input wire smc_pkg::smc_cfg_t cfg_o,
  input wire smc_pkg::smc_path_t [1:0] path_o,
  input wire logic led_blink_o
);
  import smc_pkg::*;
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  logic [1:0] rst_hist;
  logic wr_q;
  logic last_blink;
  int gap;
  logic cfg_ok;
  // cfg_o matches the live registers only without a write just before
  assign cfg_ok = &rst_hist && !wr_q;
  always_ff @(posedge clock_i) begin
    rst_hist <= {rst_hist[0], nrst_i};
    wr_q <= reg_wr_i;
  end
  always_ff @(posedge clock_i) begin
    last_blink <= led_blink_o;
    if (!nrst_i || led_blink_o != last_blink) begin
      gap <= 0;
    end else if (ce_i) begin
      gap <= gap + 1;
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  // reset clears read valid and verdict outputs
  a_reset_quiet: assert property (
    disable iff (1'b0) !nrst_i |=> !reg_rvalid_o && verdict_o == '0)
    else $error("outputs not cleared under reset");
  a_read_answer: assert property (ce_i && reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_answer_cause: assert property (
    $past(ce_i && nrst_i) |-> reg_rvalid_o == $past(reg_rd_i))
    else $error("read data valid without read");
  a_verdict_follow: assert property (ce_i |=> verdict_o.valid == $past(frame_i.valid))
    else $error("verdict valid does not follow frame");
  a_port_refused: assert property (
    ce_i && frame_i.valid && frame_i.port == 2'd3 |=> verdict_o.fwd == PORTS_NONE && !verdict_o.absorb)
    else $error("frame from invalid port forwarded");
  a_rx_disabled: assert property (
    ce_i && cfg_ok && frame_i.valid && frame_i.port != 2'd3 && !cfg_o.rx_en[frame_i.port]
    |=> verdict_o.fwd == PORTS_NONE)
    else $error("frame forwarded from disabled port");
  a_dual_split: assert property (
    ce_i && cfg_ok && cfg_o.dual_phy && frame_i.valid && frame_i.port == 2'd0 |=> !verdict_o.fwd[1])
    else $error("forwarding between paired ports in dual phy mode");
  a_pause_taken: assert property (
    verdict_o.absorb |-> $past(frame_i.da) == (GROUP_BASE | 48'h1) && verdict_o.fwd == PORTS_NONE)
    else $error("absorb on a frame that is not pause");
  a_path_onehot: assert property ($onehot(path_o[0]) && $onehot(path_o[1]))
    else $error("data path select not one hot");
  a_blink_gap: assert property (
    &rst_hist && led_blink_o != last_blink |-> gap >= BLINK_STEP_CYCLES - 1)
    else $error("blink half period too short");
endmodule : smc_regs_checker

bind smc_regs smc_regs_checker #(.BLINK_STEP_CYCLES(BLINK_STEP_CYCLES)) u_checker (
  .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rvalid_o(reg_rvalid_o), .frame_i(frame_i), .verdict_o(verdict_o), .cfg_o(cfg_o),
  .path_o(path_o), .led_blink_o(led_blink_o));

// ==== tb_top.sv ====
// self-checking testbench for the switch mac control register bank
`timescale 1ns/10ps
module tb_top;
  import smc_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int STEP = 4;
  // arbitrary identity value
  localparam logic [15:0] TB_ID = 16'h3c5a;
  localparam logic [47:0] TB_DA = 48'h02000000beef;
  localparam logic [15:0] TB_WORD = 16'h0f0f;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic cpu_port_flag_i = 1'b0;
  smc_frame_t frame_i = '0;
  logic [15:0] reg_rdata_o;
  logic reg_rvalid_o;
  smc_verdict_t verdict_o;
  smc_cfg_t cfg_o;
  smc_rate_t [2:0] rate_o;
  smc_path_t [1:0] path_o;
  logic led_blink_o;
  logic [15:0] shadow [0:10];
  logic [31:0] seed = 32'h10;
  int mismatches = 0;
  int checks_done = 0;
  always #12.5 clock_i = ~clock_i;
  smc_regs #(.BLINK_STEP_CYCLES(STEP), .CHIP_ID(TB_ID), .LB_UNICAST_DA(TB_DA),
    .LB_WORD_OTHER(TB_WORD)) dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .cpu_port_flag_i(cpu_port_flag_i), .frame_i(frame_i), .verdict_o(verdict_o),
    .cfg_o(cfg_o), .rate_o(rate_o), .path_o(path_o), .led_blink_o(led_blink_o));
  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [15:0] exp_rd(input logic [7:0] a);
    if (a == 8'h00) return TB_ID;
    if (a == 8'h07) return 16'hffff;
    if (a > 8'h0a) return 16'h0000;
    return shadow[a[3:0]];
  endfunction : exp_rd
  function automatic logic [16:0] kbps(input logic [7:0] n, input logic m);
    return 17'(n) * (m ? 17'd512 : 17'd32);
  endfunction : kbps
  function automatic smc_path_t exp_path(input logic ext, input logic [1:0] sel);
    if (!ext) return SMC_PATH_INTERNAL;
    case (sel)
      2'b00: return SMC_PATH_RS232;
      2'b01: return SMC_PATH_SMII;
      2'b10: return SMC_PATH_REV_MII;
      default: return SMC_PATH_MII;
    endcase
  endfunction : exp_path
  // forward mask and absorb flag for one frame
  function automatic logic [3:0] exp_v(input smc_frame_t f, input logic cpu);
    logic [15:0] m;
    logic [2:0] fl;
    logic [2:0] dst;
    m = shadow[1];
    if (f.port == 2'd3 || !shadow[6][f.port]) return 4'h0;
    fl = 3'b111 & ~(3'b001 << f.port);
    if (shadow[10][8] && f.port != 2'd2) fl = fl & 3'b100;
    if (f.da[47:4] != 44'h0180c200000) return {fl, 1'b0};
    case (f.da[3:0])
      4'h0: dst = (m[10] && cpu) ? 3'b100 : fl;
      4'h1: return m[5] ? {fl, 1'b0} : 4'b0001;
      4'h2: dst = !m[8] ? 3'b000 : (cpu ? 3'b100 : fl);
      4'h3: dst = (m[9] && cpu && !m[4]) ? 3'b100 : (m[4] ? fl : 3'b000);
      default: dst = m[4] ? fl : 3'b000;
    endcase
    return {dst, 1'b0};
  endfunction : exp_v
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tk();
    @(posedge clock_i);
    #1;
  endtask : tk
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic init_shadow();
    shadow = '{16'h0000, 16'h3892, 16'h0707, 16'hffff, 16'hffff, 16'hffff, 16'h0007,
      16'hffff, 16'h0000, 16'h0000, 16'h00cf};
  endtask : init_shadow
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tk();
    reg_wr_i = 1'b0;
    if (ce_i && a inside {[8'h01:8'h06], [8'h08:8'h0a]}) shadow[a[3:0]] = d;
    tk();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tk();
    reg_rd_i = 1'b0;
    chk("rvalid", reg_rvalid_o, 1'b1);
    chk("rdata", reg_rdata_o, exp);
    tk();
  endtask : rd
  task automatic chk_cfg();
    logic [15:0] d;
    d = shadow[10];
    chk("cfg_misc", cfg_o[75:70], {shadow[1][12:11], shadow[1][3:0]});
    chk("cfg_port", cfg_o[69:64], {shadow[6][2:0], d[8:6]});
    chk("lb_da", cfg_o.lb_da, shadow[9][7] ? 48'hffffffffffff : TB_DA);
    chk("lb_word", cfg_o.lb_word, shadow[9][6:4] == 3'b000 ? 16'h55aa : TB_WORD);
    for (int p = 0; p < 3; p++) begin
      chk("rate_in", rate_o[p].ingress_kbps, kbps(shadow[3+p][15:8], shadow[2][8+p]));
      chk("rate_out", rate_o[p].egress_kbps, kbps(shadow[3+p][7:0], shadow[2][p]));
    end
    for (int p = 0; p < 2; p++) begin
      chk("path", path_o[p], exp_path(d[4+p], d[2*p+:2]));
    end
  endtask : chk_cfg
  task automatic rd_all();
    for (int a = 0; a < 16; a++) begin
      rd(8'(a), exp_rd(8'(a)));
    end
    rd(8'hff, 16'h0000);
    chk_cfg();
  endtask : rd_all
  task automatic send(input smc_frame_t f);
    logic [3:0] e;
    logic h;
    e = exp_v(f, cpu_port_flag_i);
    h = shadow[8][f.port] | (shadow[8][4] & f.tag_high);
    frame_i = f;
    tk();
    chk("verdict_valid", verdict_o.valid, f.valid);
    if (f.valid) chk("route", {verdict_o.fwd, verdict_o.absorb}, e);
    if (f.valid && f.port != 2'd3) chk("high_pri", verdict_o.high_pri, h);
  endtask : send
  task automatic wait_flip(output int n);
    logic b;
    b = led_blink_o;
    n = 0;
    while (led_blink_o === b && n < 100) begin
      tk();
      n++;
    end
  endtask : wait_flip
  task automatic blink(input logic [1:0] code);
    int n;
    wr(8'h01, {1'b0, code, 13'h1892});
    wait_flip(n);
    wait_flip(n);
    chk("blink_half", 64'(n), 64'((code + 1) * STEP));
  endtask : blink
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    $display("watchdog expired");
    stop_test();
  end
  initial begin
    init_shadow();
    repeat (10) tk();
    nrst_i = 1'b1;
    tk();
    rd_all();
    $display("test reset values done");
    for (int c = 1; c < 5; c++) begin
      blink(2'(c));
    end
    $display("test blink done");
    for (int c = 0; c < 16; c++) begin
      wr(8'h0a, {7'h0, c[0], 4'b1011, 4'(c)});
      wr(8'h09, {8'h00, 4'(c), 4'h0});
      tk();
      chk_cfg();
    end
    $display("test path and loopback done");
    for (int i = 0; i < 60; i++) begin
      logic [7:0] a;
      a = 8'(xs() % 16);
      wr(a, 16'(xs()));
      rd(a, exp_rd(a));
      chk_cfg();
    end
    ce_i = 1'b0;
    wr(8'h08, 16'h0017);
    ce_i = 1'b1;
    rd(8'h08, exp_rd(8'h08));
    $display("test register access done");
    send({1'b1, 48'h0180c2000001, 2'd0, 1'b0});
    for (int i = 0; i < 240; i++) begin
      smc_frame_t f;
      if (i % 12 == 0) begin
        wr(8'h01, 16'(xs()));
        wr(8'h06, 16'(xs()));
        wr(8'h08, 16'(xs()));
        wr(8'h0a, 16'(xs()));
        cpu_port_flag_i = 1'(xs());
      end
      f = {1'b1, 16'(xs()), 32'(xs()), 3'(xs())};
      f.valid = (xs() % 8) != 0;
      if (xs() % 2 == 0) begin
        f.da = {44'h0180c200000, 4'(xs())};
        f.port[1] = 1'b0;
      end
      send(f);
    end
    $display("test frame verdicts done");
    nrst_i = 1'b0;
    tk();
    nrst_i = 1'b1;
    init_shadow();
    tk();
    rd_all();
    $display("test second reset done");
    stop_test();
  end
endmodule : tb_top
